// ---- src/codec_digital.sv ----
// Purpose: digital side of an eight channel codec
// Assumes: all link clocks sampled as inputs on core_clk
// Notes: mode pin picks serial port plus PCM, or GCI bus
module codec_digital (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic host_port_mode_select,
  input wire logic control_clock,
  input wire logic chip_select_n,
  input wire logic serial_command_line,
  output logic serial_reply_line,
  output logic serial_reply_oe,
  input wire logic pcm_bit_clock,
  input wire logic pcm_frame_sync,
  output logic pcm_tx_highway_one,
  output logic pcm_tx_highway_one_oe,
  output logic pcm_tx_highway_two,
  output logic pcm_tx_highway_two_oe,
  input wire logic pcm_rx_highway_one,
  input wire logic pcm_rx_highway_two,
  input wire logic gci_data_clock,
  input wire logic gci_frame_sync,
  input wire logic gci_double_rate,
  input wire logic slot_half_select,
  output logic upstream_line,
  output logic upstream_oe,
  input wire logic downstream_line,
  input wire logic [15:0] tx_sample [8],
  output logic [15:0] rx_sample [8],
  output logic [7:0] rx_sample_valid,
  input wire logic [5:0] ci_up_bits [4],
  input wire logic [7:0] monitor_up_byte [4],
  input wire logic monitor_transmit_flag_n,
  input wire logic monitor_receive_flag_n,
  output logic [7:0] ctl_down_byte,
  output logic [1:0] ctl_down_pair,
  output logic monitor_down_valid,
  output logic ci_down_valid
);
  // -------------------------------------------------------------
  // mode and config storage
  // -------------------------------------------------------------
  cfg_if cfg ();
  logic [7:0] global_reg; // format, rate, edge, delay
  logic [7:0] tx_slot_reg [8]; // tx index and highway
  logic [7:0] rx_slot_reg [8]; // rx index and highway
  logic pcm_mode; // serial port plus PCM
  logic gci_mode; // compressed GCI active
  logic linear; // 16-bit samples
  logic [2:0] delay; // slot offset in bit periods
  assign pcm_mode = ~host_port_mode_select;
  assign gci_mode = host_port_mode_select & ~chip_select_n;
  assign linear = global_reg[codec_pkg::FMT_BIT];
  assign delay = global_reg[codec_pkg::DLY_LSB +: 3];

  // control port only listens in serial mode
  serial_ctrl_port u_port (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .enable(pcm_mode),
    .control_clock(control_clock),
    .chip_select_n(chip_select_n),
    .serial_command_line(serial_command_line),
    .serial_reply_line(serial_reply_line),
    .serial_reply_oe(serial_reply_oe),
    .cfg(cfg.port)
  );

  // -------------------------------------------------------------
  // config writes
  // -------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      global_reg <= codec_pkg::GLOBAL_RST;
    end else if (cfg.wr_stb && cfg.addr == codec_pkg::REG_GLOBAL) begin
      global_reg <= cfg.wdata;
    end
  end

  // read mux; unmapped indexes read zero
  always_comb begin
    cfg.rdata = 8'h00;
    if (cfg.addr == codec_pkg::REG_GLOBAL) begin
      cfg.rdata = global_reg;
    end else if (cfg.addr < codec_pkg::REG_RX_BASE) begin
      cfg.rdata = tx_slot_reg[3'(cfg.addr - codec_pkg::REG_TX_BASE)];
    end else if (cfg.addr <= codec_pkg::REG_LAST) begin
      cfg.rdata = rx_slot_reg[3'(cfg.addr - codec_pkg::REG_RX_BASE)];
    end
  end

  // -------------------------------------------------------------
  // PCM bit timing
  // -------------------------------------------------------------
  logic bclk_prev_reg; // last bit clock level
  logic half_phase_reg; // skips every other edge
  logic [10:0] pcm_cnt_reg; // bits since frame sync
  logic edge_tick; // programmed edge
  logic bit_tick; // one PCM bit period
  logic [10:0] nxt_cnt; // position driven this tick
  logic [10:0] tx_pos; // tx position after delay
  logic [10:0] rx_pos; // rx position after delay

  assign edge_tick = global_reg[codec_pkg::EDGE_BIT] ? (~pcm_bit_clock & bclk_prev_reg)
                                                     : (pcm_bit_clock & ~bclk_prev_reg);
  // half rate uses every other edge
  assign bit_tick = pcm_mode & edge_tick & (~global_reg[codec_pkg::HALF_BIT] | ~half_phase_reg);
  assign nxt_cnt = pcm_frame_sync ? 11'h000 : pcm_cnt_reg + 11'h001;
  // shift slot zero by the delay
  assign tx_pos = nxt_cnt - {8'h00, delay};
  assign rx_pos = pcm_cnt_reg - {8'h00, delay};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bclk_prev_reg <= 1'b0;
    end else begin
      bclk_prev_reg <= pcm_bit_clock;
    end
  end

  // half rate phase restarts at each frame sync
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      half_phase_reg <= 1'b0;
    end else if (pcm_mode && edge_tick) begin
      half_phase_reg <= pcm_frame_sync ? 1'b1 : ~half_phase_reg;
    end
  end

  // position counter saturates so a lost sync stops traffic, except the first tx bit of slot zero at zero delay
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pcm_cnt_reg <= codec_pkg::PCM_CNT_MAX;
    end else if (bit_tick) begin
      if (pcm_frame_sync || pcm_cnt_reg != codec_pkg::PCM_CNT_MAX) begin
        pcm_cnt_reg <= nxt_cnt;
      end
    end
  end

  // 7-bit index covers 128 slots
  // hit flag, lower byte flag, bit in byte
  function automatic logic [4:0] slot_hit(input logic [10:0] p, input logic [6:0] idx,
                                          input logic lin);
    logic [6:0] d;
    d = p[9:3] - idx;
    slot_hit = {~p[10] & ((d == 7'h00) | (lin & (d == 7'h01))), d[0], p[2:0]};
  endfunction

  // -------------------------------------------------------------
  // per channel PCM slot logic
  // -------------------------------------------------------------
  logic [7:0] tx_hit; // channel owns tx bit
  logic [7:0] tx_bit; // bit value for channel
  logic [7:0] tx_two; // channel uses highway two
  logic [7:0] pcm_done; // rx sample complete
  logic [15:0] pcm_word [8]; // completed rx sample
  logic [7:0] gci_done; // GCI voice byte complete
  logic [7:0] gci_byte; // GCI byte just taken
  logic [7:0] gci_shift_reg; // GCI downstream shifter
  logic [7:0] g_cnt_reg; // GCI bit position
  logic [1:0] g_byte; // byte of sampled bit
  logic [1:0] g_pair; // slot pair of sampled bit
  logic g_rx_last; // last bit of our byte
  logic g_rx_tick; // downstream sample tick

  genvar c;
  generate
    for (c = 0; c < 8; c++) begin : g_ch
      logic [4:0] th; // tx hit decode
      logic [4:0] rh; // rx hit decode
      logic [15:0] lw; // linear word with sign copies
      logic [15:0] rx_shift_reg; // incoming bits
      logic rin; // selected rx highway
      assign th = slot_hit(tx_pos, tx_slot_reg[c][6:0], linear);
      assign rh = slot_hit(rx_pos, rx_slot_reg[c][6:0], linear);
      // bits 15 and 14 copy bit 13
      assign lw = {tx_sample[c][13], tx_sample[c][13], tx_sample[c][13:0]};
      assign tx_hit[c] = th[4];
      assign tx_bit[c] = linear ? lw[4'hF - th[3:0]] : tx_sample[c][3'h7 - th[2:0]];
      assign tx_two[c] = tx_slot_reg[c][codec_pkg::HWY_BIT];
      assign rin = rx_slot_reg[c][codec_pkg::HWY_BIT] ? pcm_rx_highway_two : pcm_rx_highway_one;
      assign pcm_done[c] = bit_tick & rh[4] & (linear ? (rh[3:0] == 4'hF) : (rh[2:0] == 3'h7));
      assign pcm_word[c] = linear ? {rx_shift_reg[14:0], rin} : {8'h00, rx_shift_reg[6:0], rin};
      // A takes even index, B odd
      assign gci_done[c] = g_rx_tick & g_rx_last & (g_pair == 2'(c / 2)) & (g_byte == 2'(c % 2));

      // per channel config, written through the control port
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          tx_slot_reg[c] <= codec_pkg::SLOT_RST;
          rx_slot_reg[c] <= codec_pkg::SLOT_RST;
        end else if (cfg.wr_stb) begin
          if (cfg.addr == codec_pkg::REG_TX_BASE + 5'(c)) begin
            tx_slot_reg[c] <= cfg.wdata;
          end
          if (cfg.addr == codec_pkg::REG_RX_BASE + 5'(c)) begin
            rx_slot_reg[c] <= cfg.wdata;
          end
        end
      end

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          rx_shift_reg <= 16'h0000;
        end else if (bit_tick && rh[4]) begin
          rx_shift_reg <= {rx_shift_reg[14:0], rin};
        end
      end

      // received sample from either bus
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          rx_sample[c] <= 16'h0000;
          rx_sample_valid[c] <= 1'b0;
        end else begin
          rx_sample_valid[c] <= pcm_done[c] | gci_done[c];
          if (pcm_done[c]) begin
            rx_sample[c] <= pcm_word[c];
          end else if (gci_done[c]) begin
            rx_sample[c] <= {8'h00, gci_byte};
          end
        end
      end
    end
  endgenerate

  // -------------------------------------------------------------
  // PCM transmit highways
  // -------------------------------------------------------------
  // enable only inside owned slots
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pcm_tx_highway_one <= 1'b0;
      pcm_tx_highway_one_oe <= 1'b0;
      pcm_tx_highway_two <= 1'b0;
      pcm_tx_highway_two_oe <= 1'b0;
    end else if (!pcm_mode) begin
      pcm_tx_highway_one_oe <= 1'b0;
      pcm_tx_highway_two_oe <= 1'b0;
    end else if (bit_tick) begin
      pcm_tx_highway_one <= |(tx_hit & ~tx_two & tx_bit);
      pcm_tx_highway_one_oe <= |(tx_hit & ~tx_two);
      pcm_tx_highway_two <= |(tx_hit & tx_two & tx_bit);
      pcm_tx_highway_two_oe <= |(tx_hit & tx_two);
    end
  end

  // -------------------------------------------------------------
  // GCI bit timing
  // -------------------------------------------------------------
  logic dcl_prev_reg; // last data clock level
  logic g_phase_reg; // second clock of a double-rate bit
  logic dcl_rise;
  logic g_tx_tick; // upstream drive tick
  logic [7:0] g_nxt; // position driven this tick
  logic g_tx_ours; // driven slot in our half
  logic g_rx_ours; // sampled slot in our half
  logic [1:0] t_pair; // pair of driven bit
  logic [7:0] up_byte; // byte being driven

  assign dcl_rise = gci_data_clock & ~dcl_prev_reg;
  // double rate spends two clocks per bit
  assign g_tx_tick = gci_mode & dcl_rise & (~gci_double_rate | g_phase_reg | gci_frame_sync);
  assign g_rx_tick = gci_mode & ~gci_data_clock & dcl_prev_reg & (~gci_double_rate | g_phase_reg);
  assign g_nxt = gci_frame_sync ? 8'h00 : g_cnt_reg + 8'h01;
  // slot half pin picks four slots
  assign g_tx_ours = g_nxt[7] == slot_half_select;
  assign g_rx_ours = g_cnt_reg[7] == slot_half_select;
  assign t_pair = g_nxt[6:5];
  assign g_pair = g_cnt_reg[6:5];
  assign g_byte = g_cnt_reg[4:3];
  assign g_rx_last = g_rx_ours & (g_cnt_reg[2:0] == 3'h7);
  assign gci_byte = {gci_shift_reg[6:0], downstream_line};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dcl_prev_reg <= 1'b0;
    end else begin
      dcl_prev_reg <= gci_data_clock;
    end
  end

  // phase is 1 during the second clock of a bit, so the next rise starts a new bit
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      g_phase_reg <= 1'b1;
    end else if (gci_mode && dcl_rise) begin
      g_phase_reg <= gci_frame_sync ? 1'b0 : ~g_phase_reg;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      g_cnt_reg <= 8'hFF;
    end else if (g_tx_tick) begin
      g_cnt_reg <= g_nxt;
    end
  end

  // voice A, voice B, monitor, C/I
  always_comb begin
    up_byte = {ci_up_bits[t_pair], monitor_receive_flag_n, monitor_transmit_flag_n};
    unique case (g_nxt[4:3])
      2'h0: up_byte = tx_sample[{t_pair, 1'b0}][7:0];
      2'h1: up_byte = tx_sample[{t_pair, 1'b1}][7:0];
      2'h2: up_byte = monitor_up_byte[t_pair];
      2'h3: up_byte = {ci_up_bits[t_pair], monitor_receive_flag_n, monitor_transmit_flag_n};
    endcase
  end

  // upstream released outside our four slots
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      upstream_line <= 1'b0;
      upstream_oe <= 1'b0;
    end else if (!gci_mode) begin
      upstream_oe <= 1'b0;
    end else if (g_tx_tick) begin
      upstream_line <= up_byte[3'h7 - g_nxt[2:0]];
      upstream_oe <= g_tx_ours;
    end
  end

  // downstream bits, MSB first
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gci_shift_reg <= 8'h00;
    end else if (g_rx_tick) begin
      gci_shift_reg <= gci_byte;
    end
  end

  // monitor and C/I to control side
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_down_byte <= 8'h00;
      ctl_down_pair <= 2'h0;
      monitor_down_valid <= 1'b0;
      ci_down_valid <= 1'b0;
    end else begin
      monitor_down_valid <= g_rx_tick & g_rx_last & (g_byte == codec_pkg::GCI_BYTE_MON);
      ci_down_valid <= g_rx_tick & g_rx_last & (g_byte == codec_pkg::GCI_BYTE_CI);
      if (g_rx_tick && g_rx_last && g_byte[1]) begin
        ctl_down_byte <= gci_byte;
        ctl_down_pair <= g_pair;
      end
    end
  end
endmodule

// ---- src/codec_pkg.sv ----
// Purpose: shared constants of the codec digital port
// Assumes: one core clock, all pins synchronous to it
// Notes: config map reached over the serial control port
package codec_pkg;
  // -------------------------------------------------------------
  // channels, counter limit and GCI byte indexes
  // -------------------------------------------------------------
  localparam int NCH = 8;
  localparam logic [10:0] PCM_CNT_MAX = 11'h7FF;
  localparam logic [1:0] GCI_BYTE_MON = 2'h2;
  localparam logic [1:0] GCI_BYTE_CI = 2'h3;
  // -------------------------------------------------------------
  // config register indexes
  // -------------------------------------------------------------
  localparam logic [4:0] REG_GLOBAL = 5'h00;
  localparam logic [4:0] REG_TX_BASE = 5'h01;
  localparam logic [4:0] REG_RX_BASE = 5'h09;
  localparam logic [4:0] REG_LAST = 5'h10;
  // global field positions
  localparam int FMT_BIT = 0;
  localparam int HALF_BIT = 1;
  localparam int EDGE_BIT = 2;
  localparam int DLY_LSB = 3;
  // slot register: index in [6:0], highway select in bit 7
  localparam int HWY_BIT = 7;
  // command byte: bit 7 high means read
  localparam int READ_BIT = 7;
  // reset values
  localparam logic [7:0] GLOBAL_RST = 8'h00;
  localparam logic [7:0] SLOT_RST = 8'h00;
endpackage

// ---- src/cfg_if.sv ----
// Purpose: config access between serial port and core
// Assumes: single core clock
// Notes: wr_stb is a one-cycle pulse
interface cfg_if;
  logic wr_stb; // write pulse
  logic [4:0] addr; // register index
  logic [7:0] wdata; // write data
  logic [7:0] rdata; // read data for addr
  modport port (output wr_stb, output addr, output wdata, input rdata);
  modport core (input wr_stb, input addr, input wdata, output rdata);
endinterface

// ---- src/serial_ctrl_port.sv ----
// Purpose: byte serial control port, command then data
// Assumes: control clock sampled as a plain input
// Notes: read returns one byte of the addressed register
module serial_ctrl_port (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic control_clock,
  input wire logic chip_select_n,
  input wire logic serial_command_line,
  output logic serial_reply_line,
  output logic serial_reply_oe,
  cfg_if.port cfg
);
  typedef enum logic [1:0] {ST_CMD, ST_WDATA, ST_REPLY} sp_state_t;
  sp_state_t state_reg; // transfer phase
  logic clk_prev_reg; // last control clock level
  logic [7:0] shift_reg; // incoming byte
  logic [2:0] bit_reg; // bits taken of current byte
  logic [3:0] rbit_reg; // reply bits sent
  logic [4:0] addr_reg; // addressed register
  logic wr_reg; // write pulse
  logic rise;
  logic fall;
  logic live;
  logic [7:0] byte_in;
  assign rise = control_clock & ~clk_prev_reg;
  assign fall = ~control_clock & clk_prev_reg;
  assign live = enable & ~chip_select_n;
  assign byte_in = {shift_reg[6:0], serial_command_line};
  assign cfg.wr_stb = wr_reg;
  assign cfg.addr = addr_reg;
  assign cfg.wdata = shift_reg;
  // -------------------------------------------------------------
  // edge history
  // -------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev_reg <= 1'b0;
    end else begin
      clk_prev_reg <= control_clock;
    end
  end
  // -------------------------------------------------------------
  // byte assembly and command decode
  // -------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_CMD;
      shift_reg <= 8'h00;
      bit_reg <= 3'h0;
      rbit_reg <= 4'h0;
      addr_reg <= 5'h00;
      wr_reg <= 1'b0;
      serial_reply_line <= 1'b0;
      serial_reply_oe <= 1'b0;
    end else begin
      wr_reg <= 1'b0;
      if (!live) begin
        state_reg <= ST_CMD;
        bit_reg <= 3'h0;
        rbit_reg <= 4'h0;
        serial_reply_oe <= 1'b0;
      end else if (state_reg == ST_REPLY) begin
        if (fall) begin
          if (rbit_reg == 4'h8) begin
            state_reg <= ST_CMD;
            serial_reply_oe <= 1'b0;
            rbit_reg <= 4'h0;
          end else begin
            serial_reply_line <= cfg.rdata[3'h7 - rbit_reg[2:0]];
            serial_reply_oe <= 1'b1;
            rbit_reg <= rbit_reg + 4'h1;
          end
        end
      end else if (rise) begin
        shift_reg <= byte_in;
        bit_reg <= bit_reg + 3'h1;
        if (bit_reg == 3'h7) begin
          if (state_reg == ST_WDATA) begin
            wr_reg <= 1'b1;
            state_reg <= ST_CMD;
          end else begin
            addr_reg <= byte_in[4:0];
            state_reg <= byte_in[codec_pkg::READ_BIT] ? ST_REPLY : ST_WDATA;
          end
        end
      end
    end
  end
endmodule

// ---- tb/codec_assertions.sv ----
// Purpose: port checks for codec_digital
// Assumes: one clock, async active-low reset
// Notes: serial clock halves span several core cycles
module codec_assertions (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic host_port_mode_select,
  input wire logic control_clock,
  input wire logic chip_select_n,
  input wire logic serial_reply_line,
  input wire logic serial_reply_oe,
  input wire logic pcm_tx_highway_one_oe,
  input wire logic pcm_tx_highway_two_oe,
  input wire logic upstream_oe,
  input wire logic [7:0] rx_sample_valid,
  input wire logic monitor_down_valid,
  input wire logic ci_down_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_abort_drops_reply: assert property (chip_select_n |=> !serial_reply_oe)
    else $error("reply driven with select high");
  a_reply_on_fall: assert property (serial_reply_oe && $changed(serial_reply_line) |-> !control_clock)
    else $error("reply changed while control clock high");
  a_pcm_off_gci: assert property (host_port_mode_select [*3] |-> !pcm_tx_highway_one_oe && !pcm_tx_highway_two_oe)
    else $error("PCM highway driven in GCI mode");
  a_up_off_serial: assert property (!host_port_mode_select [*3] |-> !upstream_oe)
    else $error("upstream driven in serial mode");
  a_no_reply_gci: assert property (host_port_mode_select [*3] |-> !serial_reply_oe)
    else $error("serial reply driven in GCI mode");
  a_linear_gci_idle: assert property ((host_port_mode_select && chip_select_n) [*3] |-> !upstream_oe)
    else $error("upstream driven with linear GCI selected");
  a_rx_valid_pulse: assert property ((rx_sample_valid & $past(rx_sample_valid)) == 8'h00)
    else $error("receive valid held two cycles");
  a_ctl_pulse_apart: assert property (monitor_down_valid || ci_down_valid |=> !monitor_down_valid && !ci_down_valid)
    else $error("control byte strobes too close");
endmodule

// ---- tb/bus_master_model.sv ----
// Purpose: bus master model: bit clock, frame sync, receive data
// Assumes: updates on falling core_clk, eight core cycles a bit
// Notes: 64 bit frames; receive lines driven the whole frame
module bus_master_model (
  input wire logic core_clk,
  input wire logic rst_n,
  output logic pcm_bit_clock,
  output logic pcm_frame_sync,
  output logic pcm_rx_highway_one,
  output logic pcm_rx_highway_two,
  output logic [5:0] pos
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] phase; // core cycles into the bit
  // constant levels make the result immune to sample offset
  assign pcm_rx_highway_one = 1'b1;
  assign pcm_rx_highway_two = 1'b0;
  always @(negedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 3'h0;
      pos <= 6'h3F;
      pcm_bit_clock <= 1'b0;
      pcm_frame_sync <= 1'b0;
    end else begin
      phase <= phase + 3'h1;
      if (phase == 3'h3) begin
        pcm_bit_clock <= 1'b1;
        pos <= pos + 6'h01;
      end
      if (phase == 3'h7) begin
        pcm_bit_clock <= 1'b0;
        pcm_frame_sync <= (pos == 6'h3F);
      end
    end
  end
endmodule

// ---- tb/tb.sv ----
// Purpose: self-checking bench for codec_digital
// Assumes: inputs change on falling core_clk
// Notes: one bus master model times both PCM and GCI
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic host_port_mode_select = 1'b0;
  logic control_clock = 1'b0;
  logic chip_select_n = 1'b1;
  logic serial_command_line = 1'b0;
  logic slot_half_select = 1'b0;
  logic gci_double_rate = 1'b0;
  logic monitor_transmit_flag_n = 1'b0;
  logic monitor_receive_flag_n = 1'b1;
  logic [15:0] tx_sample [8] = '{default: 16'h0000};
  logic [5:0] ci_up_bits [4] = '{default: 6'h2D};
  logic [7:0] monitor_up_byte [4] = '{default: 8'h96};
  wire logic pcm_bit_clock, pcm_frame_sync, pcm_rx_highway_one, pcm_rx_highway_two;
  wire logic gci_data_clock = pcm_bit_clock;
  wire logic gci_frame_sync = pcm_frame_sync;
  wire logic downstream_line = pcm_rx_highway_one;
  wire logic [5:0] pos;
  logic serial_reply_line, serial_reply_oe, upstream_line, upstream_oe, monitor_down_valid, ci_down_valid;
  logic pcm_tx_highway_one, pcm_tx_highway_one_oe, pcm_tx_highway_two, pcm_tx_highway_two_oe;
  logic [15:0] rx_sample [8];
  logic [7:0] rx_sample_valid, ctl_down_byte;
  logic [1:0] ctl_down_pair;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  always #2.5 core_clk = ~core_clk;
  codec_digital uut (.core_clk, .rst_n, .host_port_mode_select, .control_clock, .chip_select_n,
    .serial_command_line, .serial_reply_line, .serial_reply_oe, .pcm_bit_clock, .pcm_frame_sync,
    .pcm_tx_highway_one, .pcm_tx_highway_one_oe, .pcm_tx_highway_two, .pcm_tx_highway_two_oe,
    .pcm_rx_highway_one, .pcm_rx_highway_two, .gci_data_clock, .gci_frame_sync, .gci_double_rate,
    .slot_half_select, .upstream_line, .upstream_oe, .downstream_line, .tx_sample, .rx_sample,
    .rx_sample_valid, .ci_up_bits, .monitor_up_byte, .monitor_transmit_flag_n, .monitor_receive_flag_n,
    .ctl_down_byte, .ctl_down_pair, .monitor_down_valid, .ci_down_valid);
  bus_master_model partner (.core_clk, .rst_n, .pcm_bit_clock, .pcm_frame_sync, .pcm_rx_highway_one,
    .pcm_rx_highway_two, .pos);
  task automatic chk_bit(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // one serial byte, MSB first; reply taken at each rise
  task automatic xfer(input logic [7:0] out, output logic [7:0] in);
    for (int i = 7; i >= 0; i--) begin
      control_clock = 1'b0;
      serial_command_line = out[i];
      repeat (4) @(negedge core_clk);
      control_clock = 1'b1;
      in[i] = serial_reply_line;
      repeat (4) @(negedge core_clk);
    end
  endtask
  task automatic deselect();
    logic [7:0] r;
    chip_select_n = 1'b1;
    xfer(8'h00, r);
  endtask
  task automatic access(input logic [7:0] a, input logic [7:0] b, output logic [7:0] r);
    chip_select_n = 1'b0;
    xfer(a, r);
    xfer(b, r);
    deselect();
  endtask
  // bounded wait for a receive strobe (0) or control strobe (1)
  task automatic wait_pulse(input logic ci);
    for (int n = 0; n < 2000 && (ci ? ci_down_valid : rx_sample_valid[0]) !== 1'b1; n++) @(negedge core_clk);
    chk_bit("strobe seen", 1'b1, ci ? ci_down_valid : rx_sample_valid[0]);
  endtask
  // one frame, data MSB first in lo..lo+n-1; unconfigured channels sit on slot zero,
  // just before lo, and a 64-bit GCI frame lies wholly in our half of the slots
  task automatic scan(input int lo, input logic [31:0] w, input int n, input logic gci);
    int p;
    @(posedge pcm_frame_sync);
    repeat (64) begin
      @(negedge pcm_bit_clock);
      p = int'(pos) - lo;
      chk_bit("enable", gci ? n > 0 : (p >= -8 && p < n), gci ? upstream_oe : pcm_tx_highway_one_oe);
      if (p >= 0 && p < n) chk_bit("data", w[n-1-(p >> gci_double_rate)], gci ? upstream_line : pcm_tx_highway_one);
      chk_bit("highway two enable", 1'b0, pcm_tx_highway_two_oe);
    end
  endtask
  task automatic t_serial();
    logic [7:0] r;
    access({3'h0, codec_pkg::REG_TX_BASE}, 8'h01, r);
    chip_select_n = 1'b0;
    xfer({3'h4, codec_pkg::REG_TX_BASE}, r);
    xfer(8'h00, r);
    chk_word("slot read", 16'h0001, {8'h00, r});
    xfer(8'h07, r);
    deselect();
    access({3'h4, codec_pkg::REG_GLOBAL}, 8'h00, r);
    chk_word("global after read", 16'h0000, {8'h00, r});
    access(8'h87, 8'h00, r);
    chk_word("aborted write", 16'h0000, {8'h00, r});
  endtask
  task automatic t_pcm(input logic [2:0] dly);
    logic [7:0] r;
    access({3'h0, codec_pkg::REG_GLOBAL}, {2'h0, dly, 3'h0}, r);
    access({3'h0, codec_pkg::REG_RX_BASE}, 8'h01, r);
    scan(8 + int'(dly), 32'h000000A5, 8, 1'b0);
    wait_pulse(1'b0);
    chk_word("rx highway one", 16'h00FF, rx_sample[0]);
    access({3'h0, codec_pkg::REG_RX_BASE}, 8'h81, r);
    wait_pulse(1'b0);
    @(negedge core_clk);
    wait_pulse(1'b0);
    chk_word("rx highway two", 16'h0000, rx_sample[0]);
  endtask
  task automatic t_gci();
    host_port_mode_select = 1'b1;
    chip_select_n = 1'b0;
    tx_sample[1] = 16'h003C;
    scan(0, 32'hA53C96B6, 32, 1'b1);
    wait_pulse(1'b1);
    chk_word("downstream C/I", 16'h00FF, {8'h00, ctl_down_byte});
    // double rate: each bit spans two data clocks
    gci_double_rate = 1'b1;
    scan(0, 32'hA53C96B6, 32, 1'b1);
    gci_double_rate = 1'b0;
    slot_half_select = 1'b1;
    scan(0, 32'h0, 0, 1'b1);
    chip_select_n = 1'b1;
    scan(0, 32'h0, 0, 1'b1);
  endtask
  initial begin
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    tx_sample[0] = 16'h00A5;
    t_serial();
    t_pcm(3'h0);
    t_pcm(3'h7);
    t_gci();
    give_verdict();
  end
  // hang guard, well past the expected run length
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      give_verdict();
    end
  end
endmodule
bind codec_digital codec_assertions chk (.core_clk, .rst_n, .host_port_mode_select, .control_clock,
  .chip_select_n, .serial_reply_line, .serial_reply_oe, .pcm_tx_highway_one_oe, .pcm_tx_highway_two_oe,
  .upstream_oe, .rx_sample_valid, .monitor_down_valid, .ci_down_valid);
